// ==== apsc_ring_mem.sv ====
// Purpose: Shared constants and the ring format store of the port state control block.
// Assumes: One clock; synchronous clear; registered read data.
// Notes:   Four words: transmit base, transmit length, receive base, receive length.
`timescale 1ns/1ns

package apsc_pkg;
    // Register byte offsets
    localparam logic [7:0] OFF_PCW      = 8'h00;
    localparam logic [7:0] OFF_ERR      = 8'h04;
    localparam logic [7:0] OFF_BLK_LO   = 8'h08;
    localparam logic [7:0] OFF_BLK_HI   = 8'h0C;
    localparam logic [7:0] OFF_BASE     = 8'h10;
    localparam logic [7:0] OFF_UDB      = 8'h14;
    localparam logic [7:0] OFF_MODE     = 8'h18;
    localparam logic [7:0] OFF_PHYS_LO  = 8'h1C;
    localparam logic [7:0] OFF_PHYS_HI  = 8'h20;
    localparam logic [7:0] OFF_POLL_CNT = 8'h24;
    localparam logic [7:0] OFF_MCAST    = 8'h28;
    localparam logic [7:0] OFF_RING     = 8'h30;
    localparam logic [7:0] RING_MASK    = 8'hF0;
    // Primary control word fields
    localparam int CMD_MSB  = 3;
    localparam int IE_BIT   = 4;
    localparam int RST_BIT  = 5;
    localparam int IRQ_BIT  = 6;
    localparam int DONE_BIT = 7;
    localparam int ST_LSB   = 8;
    // Port commands
    localparam logic [3:0] CMD_NONE       = 4'h0;
    localparam logic [3:0] CMD_FETCH_BASE = 4'h1;
    localparam logic [3:0] CMD_FETCH_FN   = 4'h2;
    localparam logic [3:0] CMD_START      = 4'h3;
    localparam logic [3:0] CMD_BOOT       = 4'h4;
    localparam logic [3:0] CMD_TX_POLL    = 4'h5;
    localparam logic [3:0] CMD_STOP       = 4'h6;
    // Ancillary function code for write ring format
    localparam logic [7:0] FN_WRITE_RING  = 8'h09;
    // Selftest failure classes
    localparam logic [1:0] ST_PASS  = 2'h0;
    localparam logic [1:0] ST_NET   = 2'h1;
    localparam logic [1:0] ST_XFER  = 2'h2;
    // Timing
    localparam int CLK_PERIOD_NS    = 100;
    localparam int SELFTEST_TIME_NS = 2000;
    localparam int SELFTEST_CYCLES  = (SELFTEST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [31:0] WORD_STEP = 32'h0000_0004;
    // Arbitrary default station address
    localparam logic [47:0] DEFAULT_PHYS = 48'h02_00_00_00_00_01;
endpackage : apsc_pkg

module apsc_ring_mem #(
    parameter int DEPTH = 4,
    parameter int AW    = 2
) (
    input  wire logic          clk_sys_in,   // System clock
    input  wire logic          clear_in,     // Zero all words
    input  wire logic          we_in,        // Write strobe
    input  wire logic [AW-1:0] waddr_in,     // Write word index
    input  wire logic [31:0]   wdata_in,     // Write data
    input  wire logic [AW-1:0] raddr_in,     // Read word index
    output logic      [31:0]   rdata_out     // Registered read data
);
    logic [31:0] mem [DEPTH];

    always_ff @(posedge clk_sys_in) begin
        if (clear_in) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem[i] <= 32'h0000_0000;
            end
        end else if (we_in) begin
            mem[waddr_in] <= wdata_in;
        end
        rdata_out <= clear_in ? 32'h0000_0000 : mem[raddr_in];
    end
endmodule : apsc_ring_mem

// ==== apsc_port_ctrl.sv ====
// Purpose: Port state control: functional states, selftest, reset, start-up handshake.
// Assumes: AHB-Lite slave with zero wait states; host memory read port for fetches.
// Notes:   Frame datapaths are outside; this block only grants and steers them.
`timescale 1ns/1ns

// Contract
// - Running keeps all state, clears nothing
// - Primary load imposes no hardware clearing
// - Stop then restart keeps all parameters
// - Network halted only from selftest; clears status
// - Host-bus halted exits only through reset
// - Power-up selftest; pass ready, fail halted
// - Failure code on indicators and error word
// - Reset on control bit or bus init
// - Retest only if last selftest failed
// - Reset restores default station address
// - Reset empties multicast, zeroes ring lengths
// - Reset clears mode and counters
// - After reset accept commands and maintenance frames
// - Fetch block base latches address, sets done
// - Writing one clears done flag
// - Fetch function stores ring format, sets done
// - Start moves ready to running, sets done
// - Running transmit poll triggers transmission
// - Stop moves running to ready; maintenance only
// - Failure class selects the halted state
module apsc_port_ctrl (
    input  wire logic        clk_sys_in,     // System clock, 10 MHz
    input  wire logic        reset_n_in,     // Power-up reset, sync, active low
    input  wire logic        bus_init_in,    // Host-bus initialization signal
    input  wire logic        hsel_in,        // AHB select
    input  wire logic [31:0] haddr_in,       // AHB address
    input  wire logic [1:0]  htrans_in,      // AHB transfer type
    input  wire logic        hwrite_in,      // AHB write
    input  wire logic [2:0]  hsize_in,       // AHB size
    input  wire logic [31:0] hwdata_in,      // AHB write data
    input  wire logic        hready_in,      // AHB ready
    output logic             hreadyout_out,  // AHB slave ready
    output logic             hresp_out,      // AHB response
    output logic      [31:0] hrdata_out,     // AHB read data
    input  wire logic [1:0]  st_class_in,    // Selftest result class
    input  wire logic [7:0]  st_code_in,     // Selftest failure code
    output logic             dma_req_out,    // Host memory read request
    output logic      [31:0] dma_addr_out,   // Host memory read address
    input  wire logic        dma_ack_in,     // Host memory read data valid
    input  wire logic [31:0] dma_rdata_in,   // Host memory read data
    output logic             irq_out,        // Host interrupt request
    output logic      [7:0]  led_code_out,   // Edge indicator code
    output logic             rx_enable_out,  // Receive addressed frames
    output logic             maint_en_out,   // Maintenance frames allowed
    output logic             tx_poll_out,    // Transmit queued frames, pulse
    output logic      [47:0] phys_addr_out,  // Station address
    output logic      [15:0] mode_out        // Mode register
);
    typedef enum logic [2:0] {
        S_SELFTEST, S_READY, S_RUNNING, S_PRIMARY_LOAD,
        S_NET_HALT, S_BUS_HALT, S_BOTH_HALT
    } apsc_state_t;

    typedef enum logic [1:0] {F_IDLE, F_FN, F_UDB, F_RING} apsc_fetch_t;

    typedef struct packed {
        apsc_state_t state;
        apsc_fetch_t fs;
        logic [1:0]  idx;
        logic [7:0]  st_cnt;
        logic        st_failed;
        logic        ie;
        logic        done;
        logic [7:0]  err_code;
        logic [7:0]  led;
        logic [15:0] blk_lo;
        logic [15:0] blk_hi;
        logic [31:0] base;
        logic [31:0] ring_setup_block;
        logic [7:0]  fn;
        logic        dma_req;
        logic [31:0] dma_addr;
        logic [15:0] mode;
        logic [47:0] phys;
        logic [15:0] poll_cnt;
        logic [3:0]  mcast_cnt;
        logic        tx_poll;
        logic        aph_v;
        logic        a_wr;
        logic [7:0]  a_addr;
        logic [31:0] hrdata;
    } apsc_regs_t;

    localparam apsc_regs_t RESET_VAL = '{
        state: S_SELFTEST, fs: F_IDLE, phys: apsc_pkg::DEFAULT_PHYS, default: '0};

    apsc_regs_t  r;
    apsc_regs_t  next_r;
    logic        wr_pcw;
    logic [3:0]  cmd;
    logic        reset_op;
    logic        mem_we;
    logic        mem_clr;
    logic [31:0] ring_rdata;
    logic        bus_dead;

    function automatic logic is_bus_halt(input apsc_state_t s);
        return (s == S_BUS_HALT) || (s == S_BOTH_HALT);
    endfunction : is_bus_halt

    ////////////////////////////////////////////////////////////////////////////////
    // Command decode and reset request
    assign bus_dead = is_bus_halt(r.state);
    assign wr_pcw   = r.aph_v && r.a_wr && (r.a_addr == apsc_pkg::OFF_PCW);
    assign cmd      = hwdata_in[apsc_pkg::CMD_MSB:0];
    assign reset_op = bus_init_in || (wr_pcw && hwdata_in[apsc_pkg::RST_BIT]);
    assign mem_clr  = !reset_n_in || reset_op;

    ////////////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        logic [31:0] rd;
        rd     = 32'h0000_0000;
        next_r = r;
        mem_we = 1'b0;
        next_r.tx_poll = 1'b0;

        // Address phase capture and registered read data
        next_r.aph_v  = hsel_in && hready_in && htrans_in[1];
        next_r.a_wr   = hwrite_in;
        next_r.a_addr = haddr_in[7:0];
        unique case (haddr_in[7:0])
            apsc_pkg::OFF_PCW:      rd = {16'h0000, 5'h00, r.state, r.done,
                                          r.done && r.ie, 1'b0, r.ie, 4'h0};
            apsc_pkg::OFF_ERR:      rd = {24'h000000, r.err_code};
            apsc_pkg::OFF_BLK_LO:   rd = {16'h0000, r.blk_lo};
            apsc_pkg::OFF_BLK_HI:   rd = {16'h0000, r.blk_hi};
            apsc_pkg::OFF_BASE:     rd = r.base;
            apsc_pkg::OFF_UDB:      rd = r.ring_setup_block;
            apsc_pkg::OFF_MODE:     rd = {16'h0000, r.mode};
            apsc_pkg::OFF_PHYS_LO:  rd = r.phys[31:0];
            apsc_pkg::OFF_PHYS_HI:  rd = {16'h0000, r.phys[47:32]};
            apsc_pkg::OFF_POLL_CNT: rd = {16'h0000, r.poll_cnt};
            apsc_pkg::OFF_MCAST:    rd = {28'h0000000, r.mcast_cnt};
            default:                rd = 32'h0000_0000;
        endcase
        // Host cannot see anything while the host-bus side is halted
        next_r.hrdata = bus_dead ? 32'h0000_0000 : rd;

        // Data phase register writes
        if (r.aph_v && r.a_wr && !bus_dead) begin
            unique case (r.a_addr)
                apsc_pkg::OFF_BLK_LO: next_r.blk_lo = hwdata_in[15:0];
                apsc_pkg::OFF_BLK_HI: next_r.blk_hi = hwdata_in[15:0];
                apsc_pkg::OFF_MODE:   next_r.mode   = hwdata_in[15:0];
                default: ;
            endcase
        end

        // Primary control word: enable, done clear, port commands
        if (wr_pcw && !bus_dead) begin
            next_r.ie = hwdata_in[apsc_pkg::IE_BIT];
            if (hwdata_in[apsc_pkg::DONE_BIT]) begin
                next_r.done = 1'b0;
            end
            unique case (cmd)
                apsc_pkg::CMD_FETCH_BASE: begin
                    next_r.base = {r.blk_hi, r.blk_lo};
                    next_r.done = 1'b1;
                end
                apsc_pkg::CMD_FETCH_FN: begin
                    if (r.fs == F_IDLE) begin
                        next_r.fs       = F_FN;
                        next_r.dma_req  = 1'b1;
                        next_r.dma_addr = r.base;
                    end
                end
                apsc_pkg::CMD_START: begin
                    if (r.state == S_READY) begin
                        next_r.state = S_RUNNING;
                    end
                    next_r.done = 1'b1;
                end
                apsc_pkg::CMD_STOP: begin
                    if (r.state == S_RUNNING) begin
                        next_r.state = S_READY;
                    end
                    next_r.done = 1'b1;
                end
                apsc_pkg::CMD_BOOT: begin
                    if (r.state == S_READY || r.state == S_RUNNING) begin
                        next_r.state = S_PRIMARY_LOAD;
                    end
                    next_r.done = 1'b1;
                end
                apsc_pkg::CMD_TX_POLL: begin
                    if (r.state == S_RUNNING) begin
                        next_r.tx_poll  = 1'b1;
                        next_r.poll_cnt = r.poll_cnt + 16'h0001;
                    end
                end
                default: ;
            endcase
        end

        // Parameter block fetch sequence
        if (r.dma_req && dma_ack_in) begin
            unique case (r.fs)
                F_FN: begin
                    next_r.fn       = dma_rdata_in[7:0];
                    next_r.fs       = F_UDB;
                    next_r.dma_addr = r.dma_addr + apsc_pkg::WORD_STEP;
                end
                F_UDB: begin
                    next_r.ring_setup_block = dma_rdata_in;
                    // Ring format change is a no-op while running
                    if (r.fn == apsc_pkg::FN_WRITE_RING && r.state != S_RUNNING) begin
                        next_r.fs       = F_RING;
                        next_r.idx      = 2'h0;
                        next_r.dma_addr = dma_rdata_in;
                    end else begin
                        next_r.fs      = F_IDLE;
                        next_r.dma_req = 1'b0;
                        next_r.done    = 1'b1;
                    end
                end
                F_RING: begin
                    mem_we          = 1'b1;
                    next_r.idx      = r.idx + 2'h1;
                    next_r.dma_addr = r.dma_addr + apsc_pkg::WORD_STEP;
                    if (r.idx == 2'h3) begin
                        next_r.fs      = F_IDLE;
                        next_r.dma_req = 1'b0;
                        next_r.done    = 1'b1;
                    end
                end
                default: begin
                    next_r.fs      = F_IDLE;
                    next_r.dma_req = 1'b0;
                end
            endcase
        end

        // Selftest
        if (r.state == S_SELFTEST) begin
            next_r.st_cnt = r.st_cnt + 8'h01;
            if (r.st_cnt == 8'(apsc_pkg::SELFTEST_CYCLES - 1)) begin
                next_r.st_cnt = 8'h00;
                if (st_class_in == apsc_pkg::ST_PASS) begin
                    next_r.state     = S_READY;
                    next_r.st_failed = 1'b0;
                    next_r.led       = 8'h00;
                end else begin
                    next_r.st_failed = 1'b1;
                    next_r.led       = st_code_in;
                    next_r.err_code  = st_code_in;
                    unique case (st_class_in)
                        apsc_pkg::ST_NET: begin
                            next_r.state    = S_NET_HALT;
                            next_r.done     = 1'b0;
                            next_r.poll_cnt = 16'h0000;
                            next_r.mode     = 16'h0000;
                        end
                        apsc_pkg::ST_XFER: next_r.state = S_BUS_HALT;
                        default:           next_r.state = S_BOTH_HALT;
                    endcase
                end
            end
        end

        // Reset operation overrides everything else
        if (reset_op) begin
            next_r          = RESET_VAL;
            next_r.st_failed = r.st_failed;
            next_r.err_code  = r.err_code;
            next_r.led       = r.led;
            next_r.state     = r.st_failed ? S_SELFTEST : S_READY;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!reset_n_in) begin
            r <= RESET_VAL;
        end else begin
            r <= next_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Ring format store
    apsc_ring_mem #(.DEPTH(4), .AW(2)) u_ring (
        .clk_sys_in (clk_sys_in),
        .clear_in   (mem_clr),
        .we_in      (mem_we),
        .waddr_in   (r.idx),
        .wdata_in   (dma_rdata_in),
        .raddr_in   (haddr_in[3:2]),
        .rdata_out  (ring_rdata)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs
    logic ring_sel_q;
    assign ring_sel_q    = (r.a_addr & apsc_pkg::RING_MASK) == apsc_pkg::OFF_RING;
    assign hreadyout_out = 1'b1;
    assign hresp_out     = 1'b0;
    assign hrdata_out    = (ring_sel_q && !bus_dead) ? ring_rdata : r.hrdata;
    assign irq_out       = r.done && r.ie;
    assign led_code_out  = r.led;
    assign dma_req_out   = r.dma_req;
    assign dma_addr_out  = r.dma_addr;
    assign rx_enable_out = r.state == S_RUNNING;
    assign maint_en_out  = r.state == S_READY || r.state == S_RUNNING;
    assign tx_poll_out   = r.tx_poll;
    assign phys_addr_out = r.phys;
    assign mode_out      = r.mode;

    ////////////////////////////////////////////////////////////////////////////////
    // Assertions
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!reset_n_in);

    irq_follow_a: assert property (wr_pcw && cmd == apsc_pkg::CMD_FETCH_BASE
        && hwdata_in[apsc_pkg::IE_BIT] && !bus_dead && !reset_op |=> irq_out)
        else $error("irq not raised with done and enable");
    reset_clear_a: assert property (reset_op |=> r.mode == 16'h0000 && r.poll_cnt == 16'h0000
        && r.phys == apsc_pkg::DEFAULT_PHYS && r.mcast_cnt == 4'h0)
        else $error("reset left state uncleared");
    reset_path_a: assert property (reset_op && !r.st_failed |=> r.state == S_READY)
        else $error("reset without failure did not reach ready");
    retest_a: assert property (reset_op && r.st_failed |=> r.state == S_SELFTEST)
        else $error("failed selftest not rerun on reset");
    bus_halt_a: assert property (r.state == S_BUS_HALT && !reset_op |=> r.state == S_BUS_HALT)
        else $error("host-bus halted left without reset");
    start_run_a: assert property (wr_pcw && cmd == apsc_pkg::CMD_START && r.state == S_READY
        && !reset_op |=> r.state == S_RUNNING && r.done)
        else $error("start did not run");
    stop_ready_a: assert property (wr_pcw && cmd == apsc_pkg::CMD_STOP && r.state == S_RUNNING
        && !reset_op |=> r.state == S_READY && !rx_enable_out && maint_en_out)
        else $error("stop did not return to ready");
    poll_tx_a: assert property (wr_pcw && cmd == apsc_pkg::CMD_TX_POLL && r.state == S_RUNNING
        && !reset_op |=> tx_poll_out ##1 !tx_poll_out)
        else $error("poll pulse wrong");
    base_latch_a: assert property (wr_pcw && cmd == apsc_pkg::CMD_FETCH_BASE && !bus_dead
        && !reset_op |=> r.base == $past({r.blk_hi, r.blk_lo}) && r.done)
        else $error("block base not latched");
    done_clear_a: assert property (wr_pcw && hwdata_in[apsc_pkg::DONE_BIT]
        && cmd == apsc_pkg::CMD_NONE && !r.dma_req && r.state != S_SELFTEST
        && !bus_dead |=> !r.done)
        else $error("done not cleared by one");
    run_keep_a: assert property (r.state == S_RUNNING && !(r.aph_v && r.a_wr) && !reset_op
        |=> $stable(r.mode) && $stable(r.phys) && $stable(r.base))
        else $error("running state lost data");
    fail_net_a: assert property (r.state == S_SELFTEST
        && r.st_cnt == 8'(apsc_pkg::SELFTEST_CYCLES - 1) && st_class_in == apsc_pkg::ST_NET
        && !reset_op |=> r.state == S_NET_HALT && led_code_out == r.err_code && !r.done)
        else $error("network failure not reported");

    start_c: cover property (r.state == S_READY ##1 r.state == S_RUNNING);
    ring_c:  cover property (r.fs == F_RING ##1 r.fs == F_IDLE);
    fail_c:  cover property (r.state == S_SELFTEST ##1 r.state == S_BOTH_HALT);
    poll_c:  cover property (tx_poll_out);
endmodule : apsc_port_ctrl

// ==== apsc_host_mem.sv ====
// Purpose: Host memory model answering the port's read requests.
// Assumes: One word per acknowledge; latency per word set by wait_in.
// Notes:   Data lines toggle while no word is offered.
`timescale 1ns/1ns
module apsc_host_mem (
    input  wire logic        clk_sys_in,  // System clock
    input  wire logic        req_in,      // Read request level
    input  wire logic [31:0] addr_in,     // Read address
    input  wire logic [3:0]  wait_in,     // Cycles before each answer
    output logic             ack_out,     // Word valid pulse
    output logic      [31:0] rdata_out    // Word
);
    logic [31:0] mem [16];
    logic [3:0]  cnt = 4'h0;
    initial ack_out = 1'b0;
    initial rdata_out = 32'h0000_0000;
    always @(posedge clk_sys_in) begin
        ack_out <= 1'b0;
        rdata_out <= ~rdata_out;
        // One word per answer, at most every other cycle while requested; never answers a stale address
        if (req_in && !ack_out && cnt >= wait_in) begin
            ack_out <= 1'b1;
            rdata_out <= mem[addr_in[5:2]];
            cnt <= 4'h0;
        end else if (req_in) begin
            cnt <= cnt + 4'h1;
        end
    end
endmodule : apsc_host_mem

// ==== tb_apsc_port_ctrl.sv ====
// Purpose: Self-checking bench for the port state control block.
// Assumes: Zero-wait bus slave; host memory model on the read port.
// Notes:   Power-up, start-up handshake, stop/restart, resets, selftest faults.
`timescale 1ns/1ns
module tb_apsc_port_ctrl;
    logic        clk_sys_in  = 1'b0;
    logic        reset_n_in  = 1'b0;
    logic        bus_init_in = 1'b0;
    logic        hsel_in     = 1'b1;
    logic [31:0] haddr_in    = 32'h0000_0000;
    logic [1:0]  htrans_in   = 2'h0;
    logic        hwrite_in   = 1'b0;
    logic [2:0]  hsize_in    = 3'h2;
    logic [31:0] hwdata_in   = 32'h0000_0000;
    logic [1:0]  st_class_in = 2'h0;
    logic [7:0]  st_code_in  = 8'h00;
    logic [3:0]  mem_wait    = 4'h0;
    logic        hready_in, hreadyout_out, hresp_out, dma_req_out, dma_ack_in, irq_out;
    logic        rx_enable_out, maint_en_out, tx_poll_out;
    logic [31:0] hrdata_out, dma_addr_out, dma_rdata_in, rd;
    logic [7:0]  led_code_out;
    logic [47:0] phys_addr_out;
    logic [15:0] mode_out;
    int          err_count = 0;
    int          cmp_count = 0;
    int          cyc       = 0;
    int          polls     = 0;
    assign hready_in = hreadyout_out;
    apsc_port_ctrl i_apsc_port_ctrl (.clk_sys_in, .reset_n_in, .bus_init_in, .hsel_in, .haddr_in,
        .htrans_in, .hwrite_in, .hsize_in, .hwdata_in, .hready_in, .hreadyout_out, .hresp_out,
        .hrdata_out, .st_class_in, .st_code_in, .dma_req_out, .dma_addr_out, .dma_ack_in,
        .dma_rdata_in, .irq_out, .led_code_out, .rx_enable_out, .maint_en_out, .tx_poll_out,
        .phys_addr_out, .mode_out);
    apsc_host_mem i_apsc_host_mem (.clk_sys_in, .req_in(dma_req_out), .addr_in(dma_addr_out),
        .wait_in(mem_wait), .ack_out(dma_ack_in), .rdata_out(dma_rdata_in));
    always #50 clk_sys_in = ~clk_sys_in;
    always @(posedge clk_sys_in) begin
        if (tx_poll_out === 1'b1) polls++;
        cyc++;
        if (cyc == 5000) begin
            err_count++;
            end_of_test();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        haddr_in  <= {24'h000000, a};
        hwrite_in <= w;
        htrans_in <= 2'h2;
        do @(posedge clk_sys_in); while (hready_in !== 1'b1);
        htrans_in <= 2'h0;
        hwdata_in <= d;
        do @(posedge clk_sys_in); while (hready_in !== 1'b1);
        rd = hrdata_out;
    endtask : bus
    task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        bus(1'b0, a, 32'h0000_0000);
        chk(rd & m, e);
    endtask : rdc
    task automatic ring(input logic z);
        for (int i = 0; i < 4; i++) rdc(apsc_pkg::OFF_RING + 8'(4 * i), '1,
            z ? 32'h0000_0000 : i_apsc_host_mem.mem[8 + i]);
    endtask : ring
    task automatic wdone();
        int n;
        n = 0;
        do begin
            bus(1'b0, apsc_pkg::OFF_PCW, 32'h0000_0000);
            n++;
        end while (rd[apsc_pkg::DONE_BIT] !== 1'b1 && n < 60);
        chk({31'h0, rd[apsc_pkg::DONE_BIT]}, 32'h0000_0001);
    endtask : wdone
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys_in);
    endtask : tick
    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : end_of_test
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        tick(4);
        reset_n_in <= 1'b1;
        tick(25);
        rdc(apsc_pkg::OFF_PCW, 32'h700, 32'h100);
        rdc(apsc_pkg::OFF_PHYS_LO, '1, apsc_pkg::DEFAULT_PHYS[31:0]);
        rdc(apsc_pkg::OFF_PHYS_HI, '1, 32'(apsc_pkg::DEFAULT_PHYS[47:32]));
        rdc(apsc_pkg::OFF_MODE, '1, 32'h0);
        rdc(apsc_pkg::OFF_MCAST, '1, 32'h0);
        ring(1'b1);
        chk({31'h0, maint_en_out}, 32'h1);
        chk({31'h0, hresp_out}, 32'h0);
        $display("test powerup done");
        // Start-up handshake, host memory answering slowly
        bus(1'b1, apsc_pkg::OFF_PCW, 32'h10);
        bus(1'b1, apsc_pkg::OFF_BLK_LO, 32'h1000);
        bus(1'b1, apsc_pkg::OFF_BLK_HI, 32'h0001);
        bus(1'b1, apsc_pkg::OFF_PCW, 32'h11);
        rdc(apsc_pkg::OFF_PCW, 32'h80, 32'h80);
        rdc(apsc_pkg::OFF_BASE, '1, 32'h0001_1000);
        chk({31'h0, irq_out}, 32'h1);
        bus(1'b1, apsc_pkg::OFF_PCW, 32'h90);
        rdc(apsc_pkg::OFF_PCW, 32'hC0, 32'h0);
        chk({31'h0, irq_out}, 32'h0);
        i_apsc_host_mem.mem[0] = {24'h0, apsc_pkg::FN_WRITE_RING};
        i_apsc_host_mem.mem[1] = 32'h0001_1020;
        for (int i = 0; i < 4; i++) i_apsc_host_mem.mem[8 + i] = 32'h0000_4000 + 32'(i * 24);
        mem_wait <= 4'h3;
        bus(1'b1, apsc_pkg::OFF_PCW, 32'h12);
        wdone();
        chk({31'h0, dma_req_out}, 32'h0);
        ring(1'b0);
        rdc(apsc_pkg::OFF_UDB, '1, 32'h0001_1020);
        bus(1'b1, apsc_pkg::OFF_PCW, 32'h90);
        // Receive buffer entry: base, then owner bit with length
        i_apsc_host_mem.mem[12] = 32'h0000_8000;
        i_apsc_host_mem.mem[13] = 32'h8000_0600;
        $display("test handshake done");
        bus(1'b1, apsc_pkg::OFF_PCW, 32'h13);
        rdc(apsc_pkg::OFF_PCW, 32'h780, 32'h280);
        chk({31'h0, rx_enable_out}, 32'h1);
        bus(1'b1, apsc_pkg::OFF_MODE, 32'h00AB);
        bus(1'b1, apsc_pkg::OFF_PCW, 32'h15);
        tick(3);
        chk(32'(polls), 32'h1);
        rdc(apsc_pkg::OFF_POLL_CNT, '1, 32'h1);
        bus(1'b1, apsc_pkg::OFF_PCW, 32'h16);
        rdc(apsc_pkg::OFF_PCW, 32'h700, 32'h100);
        chk({30'h0, rx_enable_out, maint_en_out}, 32'h1);
        bus(1'b1, apsc_pkg::OFF_PCW, 32'h15);
        tick(3);
        chk(32'(polls), 32'h1);
        bus(1'b1, apsc_pkg::OFF_PCW, 32'h13);
        rdc(apsc_pkg::OFF_PCW, 32'h710, 32'h210);
        rdc(apsc_pkg::OFF_MODE, '1, 32'h00AB);
        ring(1'b0);
        $display("test stop restart done");
        bus(1'b1, apsc_pkg::OFF_PCW, 32'h20);
        tick(2);
        rdc(apsc_pkg::OFF_PCW, 32'h700, 32'h100);
        rdc(apsc_pkg::OFF_MODE, '1, 32'h0);
        rdc(apsc_pkg::OFF_POLL_CNT, '1, 32'h0);
        ring(1'b1);
        chk(phys_addr_out[31:0], apsc_pkg::DEFAULT_PHYS[31:0]);
        bus(1'b1, apsc_pkg::OFF_PCW, 32'h14);
        rdc(apsc_pkg::OFF_PCW, 32'h780, 32'h380);
        $display("test reset bit done");
        // Selftest faults of each class, then recovery
        st_class_in <= apsc_pkg::ST_NET;
        st_code_in <= 8'h5A;
        reset_n_in <= 1'b0;
        tick(4);
        reset_n_in <= 1'b1;
        tick(25);
        rdc(apsc_pkg::OFF_PCW, 32'h780, 32'h400);
        rdc(apsc_pkg::OFF_ERR, 32'hFF, 32'h5A);
        chk({24'h0, led_code_out}, 32'h5A);
        st_class_in <= apsc_pkg::ST_XFER;
        bus_init_in <= 1'b1;
        tick(1);
        bus_init_in <= 1'b0;
        tick(25);
        chk({30'h0, rx_enable_out, maint_en_out}, 32'h0);
        bus(1'b1, apsc_pkg::OFF_PCW, 32'h13);
        bus(1'b1, apsc_pkg::OFF_MODE, 32'h0055);
        rdc(apsc_pkg::OFF_ERR, '1, 32'h0);
        chk({15'h0, rx_enable_out, mode_out}, 32'h0);
        st_class_in <= 2'h3;
        st_code_in <= 8'h33;
        bus(1'b1, apsc_pkg::OFF_PCW, 32'h20);
        tick(25);
        chk({23'h0, maint_en_out, led_code_out}, 32'h33);
        st_class_in <= apsc_pkg::ST_PASS;
        bus_init_in <= 1'b1;
        tick(1);
        bus_init_in <= 1'b0;
        tick(25);
        rdc(apsc_pkg::OFF_PCW, 32'h700, 32'h100);
        $display("test selftest faults done");
        end_of_test();
    end
endmodule : tb_apsc_port_ctrl
